/* File: include/lsu_pkg.sv */
// Constants, opcodes and types of the logic and shift unit.
package lsu_pkg;

	// ------------------------------------------------------------
	// Bus register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_INSTR  = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_MODE   = 12'h008;
	localparam logic [5:0]  GPR_WIN     = 6'h01;
	localparam logic [5:0]  SCR_WIN     = 6'h02;
	localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
	localparam logic        MODE_RESET  = 1'h0;

	// ------------------------------------------------------------
	// System control register numbers and bit positions
	// ------------------------------------------------------------
	localparam logic [3:0] SCR_PCS = 4'hB;
	localparam logic [3:0] SCR_MQ  = 4'hA;
	localparam logic [3:0] SCR_IAR = 4'hD;
	localparam logic [3:0] SCR_ICS = 4'hE;
	localparam logic [3:0] SCR_CS  = 4'hF;
	localparam int CS_LT_BIT    = 8;
	localparam int CS_EQ_BIT    = 9;
	localparam int CS_GT_BIT    = 10;
	localparam int PCS_PRIV_BIT = 4;
	localparam int ST_PRIV_BIT  = 3;
	localparam int ST_MODE_BIT  = 4;
	localparam logic [5:0] PLUS_SIXTEEN = 6'h10;
	localparam logic [4:0] CLZ_EMPTY    = 5'h10;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_AND   = 8'hE5;
	localparam logic [7:0] OP_OR    = 8'hE3;
	localparam logic [7:0] OP_XOR   = 8'hE7;
	localparam logic [7:0] OP_CLZ   = 8'hF5;
	localparam logic [7:0] OP_AND_IMM_LOW_ZERO_FILL  = 8'hC5;
	localparam logic [7:0] OP_AND_IMM_LOW_ONE_FILL  = 8'hC6;
	localparam logic [7:0] OP_AND_IMM_HIGH_ZERO_FILL  = 8'hD5;
	localparam logic [7:0] OP_AND_IMM_HIGH_ONE_FILL  = 8'hD6;
	localparam logic [7:0] OP_OIL   = 8'hC4;
	localparam logic [7:0] OP_OIU   = 8'hC3;
	localparam logic [7:0] OP_XIL   = 8'hC7;
	localparam logic [7:0] OP_XIU   = 8'hD7;
	localparam logic [7:0] OP_SAR   = 8'hB0;
	localparam logic [7:0] OP_ARITH_RIGHT_SHIFT_IMM  = 8'hA0;
	localparam logic [7:0] OP_SARIP = 8'hA1;
	localparam logic [7:0] OP_SR    = 8'hB8;
	localparam logic [7:0] OP_SRI   = 8'hA8;
	localparam logic [7:0] OP_SRIP  = 8'hA9;
	localparam logic [7:0] OP_SRP   = 8'hB9;
	localparam logic [7:0] OP_PAIRED_RIGHT_SHIFT_IMM  = 8'hAC;
	localparam logic [7:0] OP_SRPIP = 8'hAD;
	localparam logic [7:0] OP_SL    = 8'hBA;
	localparam logic [7:0] OP_SLI   = 8'hAA;
	localparam logic [7:0] OP_SLIP  = 8'hAB;
	localparam logic [7:0] OP_SLP   = 8'hBB;
	localparam logic [7:0] OP_PAIRED_LEFT_SHIFT_IMM  = 8'hAE;
	localparam logic [7:0] OP_SLPIP = 8'hAF;
	localparam logic [7:0] OP_MTS   = 8'hB5;
	localparam logic [7:0] OP_MFS   = 8'h96;
	localparam logic [7:0] OP_CONTROL_BIT_SET_OP = 8'h97;
	localparam logic [7:0] OP_CONTROL_BIT_CLEAR_OP = 8'h98;
	localparam logic [7:0] OP_SVC   = 8'hC0;
	localparam logic [7:0] OP_LPS   = 8'hD0;
	localparam logic [7:0] OP_WAIT  = 8'hF0;

	typedef enum logic [3:0] {
		LOP_AND, LOP_OR, LOP_XOR, LOP_AND_LZ, LOP_AND_LO, LOP_AND_HZ,
		LOP_AND_HO, LOP_OR_L, LOP_OR_H, LOP_XOR_L, LOP_XOR_H, LOP_CLZ
	} lsu_lop_t;

	typedef enum {ST_IDLE, ST_RDWAIT} lsu_bus_state_t;

endpackage

/* File: include/lsu_dp_if.sv */
// Operand and result bundle between the control core and the datapath units.
interface lsu_dp_if;
	logic [31:0]       opa;
	logic [31:0]       opb;
	logic [15:0]       imm;
	lsu_pkg::lsu_lop_t lsel;
	logic [5:0]        shamt;
	logic              sleft;
	logic              sarith;
	logic [31:0]       lres;
	logic [31:0]       sres;

	modport ctl (output opa, opb, imm, lsel, shamt, sleft, sarith, input lres, sres);
	modport lgc (input opa, opb, imm, lsel, output lres);
	modport shf (input opa, shamt, sleft, sarith, output sres);
endinterface

/* File: rtl/lsu_logic.sv */
// Bitwise logic and leading-zero count unit.
module lsu_logic (
	lsu_dp_if.lgc dp	// Operands in, logic result out.
);
	logic [4:0] lzc;

	always_comb begin
		lzc = lsu_pkg::CLZ_EMPTY;
		for (int i = 0; i < 16; i++) begin
			if (dp.opb[i]) begin
				lzc = 5'(15 - i);
			end
		end
		case (dp.lsel)
			lsu_pkg::LOP_AND:    dp.lres = dp.opa & dp.opb;
			lsu_pkg::LOP_OR:     dp.lres = dp.opa | dp.opb;
			lsu_pkg::LOP_XOR:    dp.lres = dp.opa ^ dp.opb;
			lsu_pkg::LOP_AND_LZ: dp.lres = dp.opb & {16'h0000, dp.imm};
			lsu_pkg::LOP_AND_LO: dp.lres = dp.opb & {16'hFFFF, dp.imm};
			lsu_pkg::LOP_AND_HZ: dp.lres = dp.opb & {dp.imm, 16'h0000};
			lsu_pkg::LOP_AND_HO: dp.lres = dp.opb & {dp.imm, 16'hFFFF};
			lsu_pkg::LOP_OR_L:   dp.lres = dp.opb | {16'h0000, dp.imm};
			lsu_pkg::LOP_OR_H:   dp.lres = dp.opb | {dp.imm, 16'h0000};
			lsu_pkg::LOP_XOR_L:  dp.lres = dp.opb ^ {16'h0000, dp.imm};
			lsu_pkg::LOP_XOR_H:  dp.lres = dp.opb ^ {dp.imm, 16'h0000};
			lsu_pkg::LOP_CLZ:    dp.lres = {27'h0000000, lzc};
			default:             dp.lres = dp.opa;
		endcase
	end
endmodule

/* File: rtl/lsu_shifter.sv */
// Barrel shifter for logical, arithmetic and left shifts.
module lsu_shifter (
	lsu_dp_if.shf dp	// Operand and distance in, shifted value out.
);
	always_comb begin
		if (dp.shamt > 6'h1F) begin
			dp.sres = (dp.sarith && !dp.sleft) ? {32{dp.opa[31]}} : 32'h0000_0000;
		end else if (dp.sleft) begin
			dp.sres = dp.opa << dp.shamt[4:0];
		end else if (dp.sarith) begin
			dp.sres = $signed(dp.opa) >>> dp.shamt[4:0];
		end else begin
			dp.sres = dp.opa >> dp.shamt[4:0];
		end
	end
endmodule

/* File: rtl/lsu_top.sv */
// Logic, shift and system control execution unit with an AHB-Lite register slave.
//
// Notes on behaviour
// - AND of both registers goes to first register; flags updated.
// - Low-half AND immediate with zero or one fill in upper half.
// - High-half AND immediate with zero or one fill in lower half.
// - OR of both registers goes to first register; flags updated.
// - OR immediate placed low or high, other half zero.
// - XOR of both registers goes to first register; flags updated.
// - XOR immediate placed low or high, other half zero.
// - Count zeroes above leftmost one in low halfword; empty gives 16.
// - Leading-zero count leaves the flags alone.
// - Logic results set less-than, zero or greater flag as signed value.
// - Shifts set flags from the value actually written.
// - Immediate shifts take distance 0 to 31 from the immediate.
// - Register shifts take six low bits of second register; above 31 is full.
// - Plus-sixteen shifts add 16 to the immediate distance.
// - Non-arithmetic shifts fill vacated bits with zeroes.
// - Arithmetic right shifts fill with the original sign bit.
// - Paired shifts write the twin register; first register unchanged.
// - Control registers can be read, written, and low 16 bits set or cleared.
// - Move-to copies second register into selected control register.
// - Hardware changes control registers except interrupt control status.
// - Unprivileged control ops only on quotient or status register, else trap; supervisor call never traps.
// - Shifts never raise a privilege exception.
// - Logic ops never raise a privilege exception.
module lsu_top (
	input  wire logic        hclk,             // Clock, 50 MHz.
	input  wire logic        hresetn,          // Asynchronous reset, active low.
	input  wire logic        hsel,             // Slave select.
	input  wire logic [31:0] haddr,            // Byte address.
	input  wire logic [1:0]  htrans,           // Transfer type.
	input  wire logic        hwrite,           // Write when high.
	input  wire logic [2:0]  hsize,            // Transfer size, word only.
	input  wire logic [31:0] hwdata,           // Write data.
	input  wire logic        hready,           // Bus ready.
	output logic             hreadyout,        // Slave ready.
	output logic             hresp,            // Response, always OKAY.
	output logic [31:0]      hrdata,           // Read data.
	output logic             program_check,    // One-cycle privilege trap pulse.
	output logic             less_than_flag,   // Condition: negative.
	output logic             zero_result_flag, // Condition: zero.
	output logic             greater_flag      // Condition: positive.
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	lsu_pkg::lsu_bus_state_t st;
	lsu_pkg::lsu_bus_state_t next_st;
	logic        wr_pend;
	logic        next_wr_pend;
	logic [11:0] acc_addr;
	logic [11:0] next_acc_addr;
	logic        rdy;
	logic        next_rdy;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	logic        pchk;
	logic        next_pchk;
	logic        unpriv;
	logic        next_unpriv;
	logic [31:0] gpr      [16];
	logic [31:0] next_gpr [16];
	logic [31:0] system_control_register      [16];
	logic [31:0] next_scr [16];

	// ------------------------------------------------------------
	// Decode and datapath signals
	// ------------------------------------------------------------
	logic        take;
	logic        exec;
	logic [7:0]  op;
	logic [3:0]  r2;
	logic [3:0]  r3;
	logic [3:0]  twin;
	logic [15:0] imm;
	logic [5:0]  dist_reg;
	logic [5:0]  dist_imm;
	logic [5:0]  dist_plus;
	logic [31:0] res;
	logic [3:0]  dst;
	logic        wr_gpr;
	logic        upd_flags;
	logic        use_shift;
	logic        sysop;
	logic        sys_free;
	logic        trap;
	logic [31:0] rd_mux;

	lsu_dp_if dp ();

	lsu_logic u_logic (
		.dp (dp)
	);

	lsu_shifter u_shifter (
		.dp (dp)
	);

	assign hreadyout        = rdy;
	assign hresp            = 1'b0;
	assign hrdata           = rdat;
	assign program_check    = pchk;
	assign less_than_flag   = system_control_register[lsu_pkg::SCR_CS][lsu_pkg::CS_LT_BIT];
	assign zero_result_flag = system_control_register[lsu_pkg::SCR_CS][lsu_pkg::CS_EQ_BIT];
	assign greater_flag     = system_control_register[lsu_pkg::SCR_CS][lsu_pkg::CS_GT_BIT];

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	// An instruction runs in the data phase of its write, so it is complete
	// before any following read can sample the registers.
	assign exec = wr_pend && (acc_addr == lsu_pkg::ADDR_INSTR);
	assign op   = hwdata[31:24];
	assign r2   = hwdata[23:20];
	assign r3   = hwdata[19:16];
	assign imm  = hwdata[15:0];
	assign twin = {r2[3:1], ~r2[0]};
	assign dist_reg  = gpr[r3][5:0];
	assign dist_imm  = {1'b0, imm[4:0]};
	assign dist_plus = dist_imm + lsu_pkg::PLUS_SIXTEEN;

	always_comb begin
		dp.opa    = gpr[r2];
		dp.opb    = gpr[r3];
		dp.imm    = imm;
		dp.lsel   = lsu_pkg::LOP_AND;
		dp.shamt  = dist_reg;
		dp.sleft  = 1'b0;
		dp.sarith = 1'b0;
		dst       = r2;
		wr_gpr    = 1'b0;
		upd_flags = 1'b0;
		use_shift = 1'b0;
		sysop     = 1'b0;
		case (op)
			lsu_pkg::OP_AND: begin
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_OR: begin
				dp.lsel   = lsu_pkg::LOP_OR;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_XOR: begin
				dp.lsel   = lsu_pkg::LOP_XOR;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_AND_IMM_LOW_ZERO_FILL, lsu_pkg::OP_AND_IMM_LOW_ONE_FILL: begin
				dp.lsel   = (op == lsu_pkg::OP_AND_IMM_LOW_ZERO_FILL) ? lsu_pkg::LOP_AND_LZ : lsu_pkg::LOP_AND_LO;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_AND_IMM_HIGH_ZERO_FILL, lsu_pkg::OP_AND_IMM_HIGH_ONE_FILL: begin
				dp.lsel   = (op == lsu_pkg::OP_AND_IMM_HIGH_ZERO_FILL) ? lsu_pkg::LOP_AND_HZ : lsu_pkg::LOP_AND_HO;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_OIL, lsu_pkg::OP_OIU: begin
				dp.lsel   = (op == lsu_pkg::OP_OIL) ? lsu_pkg::LOP_OR_L : lsu_pkg::LOP_OR_H;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_XIL, lsu_pkg::OP_XIU: begin
				dp.lsel   = (op == lsu_pkg::OP_XIL) ? lsu_pkg::LOP_XOR_L : lsu_pkg::LOP_XOR_H;
				wr_gpr    = 1'b1;
				upd_flags = 1'b1;
			end
			lsu_pkg::OP_CLZ: begin
				dp.lsel = lsu_pkg::LOP_CLZ;
				wr_gpr  = 1'b1;
			end
			lsu_pkg::OP_SAR, lsu_pkg::OP_ARITH_RIGHT_SHIFT_IMM, lsu_pkg::OP_SARIP: begin
				dp.sarith = 1'b1;
				use_shift = 1'b1;
			end
			lsu_pkg::OP_SR, lsu_pkg::OP_SRI, lsu_pkg::OP_SRIP: begin
				use_shift = 1'b1;
			end
			lsu_pkg::OP_SL, lsu_pkg::OP_SLI, lsu_pkg::OP_SLIP: begin
				dp.sleft  = 1'b1;
				use_shift = 1'b1;
			end
			lsu_pkg::OP_SRP, lsu_pkg::OP_PAIRED_RIGHT_SHIFT_IMM, lsu_pkg::OP_SRPIP: begin
				dst       = twin;
				use_shift = 1'b1;
			end
			lsu_pkg::OP_SLP, lsu_pkg::OP_PAIRED_LEFT_SHIFT_IMM, lsu_pkg::OP_SLPIP: begin
				dp.sleft  = 1'b1;
				dst       = twin;
				use_shift = 1'b1;
			end
			lsu_pkg::OP_MTS, lsu_pkg::OP_MFS, lsu_pkg::OP_CONTROL_BIT_SET_OP, lsu_pkg::OP_CONTROL_BIT_CLEAR_OP,
			lsu_pkg::OP_SVC, lsu_pkg::OP_LPS, lsu_pkg::OP_WAIT: begin
				sysop = 1'b1;
			end
			default: begin
				wr_gpr = 1'b0;
			end
		endcase
		case (op)
			lsu_pkg::OP_ARITH_RIGHT_SHIFT_IMM, lsu_pkg::OP_SRI, lsu_pkg::OP_SLI,
			lsu_pkg::OP_PAIRED_RIGHT_SHIFT_IMM, lsu_pkg::OP_PAIRED_LEFT_SHIFT_IMM: begin
				dp.shamt = dist_imm;
			end
			lsu_pkg::OP_SARIP, lsu_pkg::OP_SRIP, lsu_pkg::OP_SLIP,
			lsu_pkg::OP_SRPIP, lsu_pkg::OP_SLPIP: begin
				dp.shamt = dist_plus;
			end
			default: begin
				dp.shamt = dist_reg;
			end
		endcase
		if (use_shift) begin
			wr_gpr    = 1'b1;
			upd_flags = 1'b1;
		end
	end

	assign res = use_shift ? dp.sres : dp.lres;

	assign sys_free = (op == lsu_pkg::OP_SVC)
		|| (((op == lsu_pkg::OP_MTS) || (op == lsu_pkg::OP_MFS)
		|| (op == lsu_pkg::OP_CONTROL_BIT_SET_OP) || (op == lsu_pkg::OP_CONTROL_BIT_CLEAR_OP))
		&& ((r2 == lsu_pkg::SCR_MQ) || (r2 == lsu_pkg::SCR_CS)));
	assign trap = exec && unpriv && sysop && !sys_free;

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = lsu_pkg::WORD_RESET;
		if (acc_addr == lsu_pkg::ADDR_STATUS) begin
			rd_mux[2:0] = {greater_flag, zero_result_flag, less_than_flag};
			rd_mux[lsu_pkg::ST_PRIV_BIT] = system_control_register[lsu_pkg::SCR_PCS][lsu_pkg::PCS_PRIV_BIT];
			rd_mux[lsu_pkg::ST_MODE_BIT] = unpriv;
		end else if (acc_addr == lsu_pkg::ADDR_MODE) begin
			rd_mux[0] = unpriv;
		end else if (acc_addr[11:6] == lsu_pkg::GPR_WIN) begin
			rd_mux = gpr[acc_addr[5:2]];
		end else if (acc_addr[11:6] == lsu_pkg::SCR_WIN) begin
			rd_mux = system_control_register[acc_addr[5:2]];
		end
	end

	// ------------------------------------------------------------
	// Bus slave and register next state
	// ------------------------------------------------------------
	assign take = hsel && hready && htrans[1];

	always_comb begin
		next_st       = st;
		next_wr_pend  = 1'b0;
		next_acc_addr = acc_addr;
		next_rdy      = rdy;
		next_rdat     = rdat;
		next_pchk     = 1'b0;
		next_unpriv   = unpriv;
		next_gpr      = gpr;
		next_scr      = system_control_register;
		case (st)
			lsu_pkg::ST_IDLE: begin
				if (take) begin
					next_acc_addr = haddr[11:0];
					next_wr_pend  = hwrite;
					if (!hwrite) begin
						next_st  = lsu_pkg::ST_RDWAIT;
						next_rdy = 1'b0;
					end
				end
			end
			lsu_pkg::ST_RDWAIT: begin
				next_rdat = rd_mux;
				next_rdy  = 1'b1;
				next_st   = lsu_pkg::ST_IDLE;
			end
			default: begin
				next_st  = lsu_pkg::ST_IDLE;
				next_rdy = 1'b1;
			end
		endcase
		// Bus writes land in the data phase.
		if (wr_pend) begin
			if (acc_addr == lsu_pkg::ADDR_MODE) begin
				next_unpriv = hwdata[0];
			end else if (acc_addr[11:6] == lsu_pkg::GPR_WIN) begin
				next_gpr[acc_addr[5:2]] = hwdata;
			end else if (acc_addr[11:6] == lsu_pkg::SCR_WIN) begin
				next_scr[acc_addr[5:2]] = hwdata;
			end
		end
		if (exec && !trap) begin
			if (wr_gpr) begin
				next_gpr[dst] = res;
			end
			if (upd_flags) begin
				next_scr[lsu_pkg::SCR_CS][lsu_pkg::CS_LT_BIT] = res[31];
				next_scr[lsu_pkg::SCR_CS][lsu_pkg::CS_EQ_BIT] = (res == 32'h0000_0000);
				next_scr[lsu_pkg::SCR_CS][lsu_pkg::CS_GT_BIT] = !res[31] && (res != 32'h0000_0000);
			end
			case (op)
				lsu_pkg::OP_MTS: begin
					next_scr[r2] = gpr[r3];
				end
				lsu_pkg::OP_MFS: begin
					next_gpr[r3] = system_control_register[r2];
				end
				lsu_pkg::OP_CONTROL_BIT_SET_OP: begin
					next_scr[r2][imm[3:0]] = 1'b1;
				end
				lsu_pkg::OP_CONTROL_BIT_CLEAR_OP: begin
					next_scr[r2][imm[3:0]] = 1'b0;
				end
				default: begin
					next_pchk = 1'b0;
				end
			endcase
		end
		if (trap) begin
			next_scr[lsu_pkg::SCR_PCS][lsu_pkg::PCS_PRIV_BIT] = 1'b1;
			next_pchk = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// only bus and instruction paths write the interrupt control status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st       <= lsu_pkg::ST_IDLE;
			wr_pend  <= 1'b0;
			acc_addr <= 12'h000;
			rdy      <= 1'b1;
			rdat     <= lsu_pkg::WORD_RESET;
			pchk     <= 1'b0;
			unpriv   <= lsu_pkg::MODE_RESET;
			for (int i = 0; i < 16; i++) begin
				gpr[i] <= lsu_pkg::WORD_RESET;
				system_control_register[i] <= lsu_pkg::WORD_RESET;
			end
		end else begin
			st       <= next_st;
			wr_pend  <= next_wr_pend;
			acc_addr <= next_acc_addr;
			rdy      <= next_rdy;
			rdat     <= next_rdat;
			pchk     <= next_pchk;
			unpriv   <= next_unpriv;
			gpr      <= next_gpr;
			system_control_register      <= next_scr;
		end
	end
endmodule

/* File: sim/lsu_top_chk.sv */
// Bus handshake, trap pulse and condition flag checker for the logic and shift unit.
module lsu_top_chk (
	input wire logic        hclk,             // Clock.
	input wire logic        hresetn,          // Reset, active low.
	input wire logic        hsel,             // Select.
	input wire logic [31:0] haddr,            // Address.
	input wire logic [1:0]  htrans,           // Transfer type.
	input wire logic        hwrite,           // Write.
	input wire logic [2:0]  hsize,            // Size.
	input wire logic [31:0] hwdata,           // Write data.
	input wire logic        hready,           // Bus ready.
	input wire logic        hreadyout,        // Slave ready.
	input wire logic        hresp,            // Response.
	input wire logic [31:0] hrdata,           // Read data.
	input wire logic        program_check,    // Trap pulse.
	input wire logic        less_than_flag,   // Negative.
	input wire logic        zero_result_flag, // Zero.
	input wire logic        greater_flag      // Positive.
);
	wire logic tk = hsel & hready & htrans[1];
	logic      dph;
	logic      iph;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph <= 1'b0;
			iph <= 1'b0;
		end else if (hready) begin
			dph <= tk & hwrite;
			iph <= tk & hwrite & (haddr[11:0] == 12'h000);
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	chk_read_wait: assert property (tk && !hwrite |=> s_rd_wait)
		else $error("read did not wait exactly one cycle");
	chk_write_nowait: assert property (tk && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	chk_wait_once: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not OKAY");
	chk_rdata_load: assert property (!$stable(hrdata) |-> $past(!hreadyout))
		else $error("read data changed outside a read");
	chk_pc_pulse: assert property (program_check |=> !program_check)
		else $error("trap pulse longer than one cycle");
	chk_pc_cause: assert property (program_check |-> $past(iph))
		else $error("trap without an executed instruction");
	chk_flag_onehot: assert property ($onehot0({less_than_flag, zero_result_flag, greater_flag}))
		else $error("more than one condition flag set");
	chk_flag_cause: assert property (!$stable({less_than_flag, zero_result_flag,
		greater_flag}) |-> $past(dph))
		else $error("flags changed without a write");
	cover property (program_check);
endmodule

bind lsu_top lsu_top_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready, .hreadyout, .hresp, .hrdata, .program_check, .less_than_flag,
	.zero_result_flag, .greater_flag);

/* File: sim/tb.sv */
// Self-checking bench for the logic, shift and system control unit.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire logic   hready;
	logic        hreadyout, hresp, program_check;
	logic        less_than_flag, zero_result_flag, greater_flag;
	int          num_errors = 0, checked = 0, cyc = 0, pc_cnt = 0;

	assign hready = hreadyout;

	lsu_top i_lsu_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .program_check, .less_than_flag,
		.zero_result_flag, .greater_flag);

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (program_check === 1'b1) pc_cnt++;
		if (cyc == 40000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
		q = hrdata;
		if (n >= 50) num_errors++;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask

	task automatic exec(input logic [7:0] op, input logic [3:0] f, input logic [3:0] s,
		input logic [15:0] i);
		wr(32'h0, {op, f, s, i});
	endtask

	function automatic logic [31:0] gpr(input logic [3:0] n);
		return 32'h40 + {26'h0, n, 2'h0};
	endfunction

	function automatic logic [31:0] system_control_register(input logic [3:0] n);
		return 32'h80 + {26'h0, n, 2'h0};
	endfunction

	task automatic chkf(input logic [31:0] v);
		chk("flags", {29'h0, less_than_flag, zero_result_flag, greater_flag},
			v[31] ? 32'h4 : (v == 32'h0) ? 32'h2 : 32'h1);
	endtask

	function automatic logic [31:0] lexp(input logic [7:0] op, input logic [31:0] a, b,
		input logic [15:0] i);
		case (op)
			lsu_pkg::OP_AND:  return a & b;
			lsu_pkg::OP_OR:   return a | b;
			lsu_pkg::OP_XOR:  return a ^ b;
			lsu_pkg::OP_AND_IMM_LOW_ZERO_FILL: return b & {16'h0000, i};
			lsu_pkg::OP_AND_IMM_LOW_ONE_FILL: return b & {16'hFFFF, i};
			lsu_pkg::OP_AND_IMM_HIGH_ZERO_FILL: return b & {i, 16'h0000};
			lsu_pkg::OP_AND_IMM_HIGH_ONE_FILL: return b & {i, 16'hFFFF};
			lsu_pkg::OP_OIL:  return b | {16'h0000, i};
			lsu_pkg::OP_OIU:  return b | {i, 16'h0000};
			lsu_pkg::OP_XIL:  return b ^ {16'h0000, i};
			default:          return b ^ {i, 16'h0000};
		endcase
	endfunction

	task automatic t_reset();
		rd(32'h4, r);
		chk("status reset", r, 32'h0);
		rd(32'h8, r);
		chk("mode reset", r, 32'h0);
		rd(gpr(4'hF), r);
		chk("register reset", r, 32'h0);
		chk("flags reset", {29'h0, less_than_flag, zero_result_flag, greater_flag}, 32'h0);
		chk("response", {31'h0, hresp}, 32'h0);
		wr(32'hC0, 32'hFFFF_FFFF);
		rd(32'hC0, r);
		chk("unmapped read", r, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_logic();
		logic [7:0]  ops [11] = '{lsu_pkg::OP_AND, lsu_pkg::OP_OR, lsu_pkg::OP_XOR,
			lsu_pkg::OP_AND_IMM_LOW_ZERO_FILL, lsu_pkg::OP_AND_IMM_LOW_ONE_FILL, lsu_pkg::OP_AND_IMM_HIGH_ZERO_FILL, lsu_pkg::OP_AND_IMM_HIGH_ONE_FILL,
			lsu_pkg::OP_OIL, lsu_pkg::OP_OIU, lsu_pkg::OP_XIL, lsu_pkg::OP_XIU};
		logic [31:0] a [2] = '{32'h8F0F_3C5A, 32'h1234_5678};
		logic [31:0] b [2] = '{32'hF0F0_A5C3, 32'h1234_5678};
		logic [15:0] im [2] = '{16'h9A6C, 16'h0000};
		logic [31:0] e;
		for (int p = 0; p < 2; p++) begin
			for (int j = 0; j < 11; j++) begin
				wr(gpr(4'h2), a[p]);
				wr(gpr(4'h3), b[p]);
				exec(ops[j], 4'h2, 4'h3, im[p]);
				rd(gpr(4'h2), r);
				e = lexp(ops[j], a[p], b[p], im[p]);
				chk("logic result", r, e);
				chkf(e);
			end
		end
		$display("t_logic done");
	endtask

	task automatic t_clz();
		logic [31:0] v [4] = '{32'hFFFF_0000, 32'h0000_0001, 32'h0001_8000, 32'h0000_0F00};
		logic [31:0] n [4] = '{32'h10, 32'hF, 32'h0, 32'h4};
		for (int j = 0; j < 4; j++) begin
			wr(gpr(4'h7), 32'h8000_0000);
			exec(lsu_pkg::OP_OR, 4'h7, 4'h7, 16'h0000);
			wr(gpr(4'h9), v[j]);
			exec(lsu_pkg::OP_CLZ, 4'h8, 4'h9, 16'h0000);
			rd(gpr(4'h8), r);
			chk("zero count", r, n[j]);
			chkf(32'h8000_0000);
		end
		$display("t_clz done");
	endtask

	task automatic t_shift();
		logic [7:0]  ops [15] = '{lsu_pkg::OP_SAR, lsu_pkg::OP_ARITH_RIGHT_SHIFT_IMM, lsu_pkg::OP_SARIP,
			lsu_pkg::OP_SR, lsu_pkg::OP_SRI, lsu_pkg::OP_SRIP, lsu_pkg::OP_SRP,
			lsu_pkg::OP_PAIRED_RIGHT_SHIFT_IMM, lsu_pkg::OP_SRPIP, lsu_pkg::OP_SL, lsu_pkg::OP_SLI,
			lsu_pkg::OP_SLIP, lsu_pkg::OP_SLP, lsu_pkg::OP_PAIRED_LEFT_SHIFT_IMM, lsu_pkg::OP_SLPIP};
		logic [4:0]  dsc [15] = '{5'h06, 5'h04, 5'h05, 5'h02, 5'h00, 5'h01, 5'h12, 5'h10,
			5'h11, 5'h0A, 5'h08, 5'h09, 5'h1A, 5'h18, 5'h19};
		logic [15:0] im [2] = '{16'hFFE0, 16'h000F};
		logic [31:0] rw [2] = '{32'hFFFF_FFC3, 32'h0000_0020};
		logic [31:0] v [2] = '{32'h9234_5678, 32'h4321_8765};
		logic [31:0] e;
		logic [3:0]  f;
		int          d;
		for (int p = 0; p < 2; p++) begin
			for (int j = 0; j < 15; j++) begin
				f = (p == 1) ? 4'h5 : 4'h4;
				wr(gpr(f), v[p]);
				wr(gpr(f ^ 4'h1), 32'h5A5A_5A5A);
				wr(gpr(4'h6), rw[p]);
				exec(ops[j], f, 4'h6, im[p]);
				d = rw[p][5:0];
				if (dsc[j][1:0] == 2'h0) d = im[p][4:0];
				if (dsc[j][1:0] == 2'h1) d = im[p][4:0] + 16;
				if (d > 31) e = (dsc[j][3:2] == 2'h1) ? {32{v[p][31]}} : 32'h0;
				else if (dsc[j][3:2] == 2'h1) e = $signed(v[p]) >>> d;
				else if (dsc[j][3:2] == 2'h2) e = v[p] << d;
				else e = v[p] >> d;
				rd(gpr(f), r);
				chk("shift source", r, dsc[j][4] ? v[p] : e);
				rd(gpr(f ^ 4'h1), r);
				chk("shift twin", r, dsc[j][4] ? e : 32'h5A5A_5A5A);
				chkf(e);
			end
		end
		$display("t_shift done");
	endtask

	task automatic t_sys();
		wr(gpr(4'h1), 32'hA5C3_0F69);
		exec(lsu_pkg::OP_MTS, 4'h3, 4'h1, 16'h0000);
		rd(system_control_register(4'h3), r);
		chk("control write", r, 32'hA5C3_0F69);
		exec(lsu_pkg::OP_CONTROL_BIT_SET_OP, 4'h3, 4'h0, 16'h0001);
		rd(system_control_register(4'h3), r);
		chk("control bit set", r, 32'hA5C3_0F6B);
		exec(lsu_pkg::OP_CONTROL_BIT_CLEAR_OP, 4'h3, 4'h0, 16'h0001);
		rd(system_control_register(4'h3), r);
		chk("control bit clear", r, 32'hA5C3_0F69);
		exec(lsu_pkg::OP_MTS, 4'hE, 4'h1, 16'h0000);
		rd(system_control_register(4'hE), r);
		chk("interrupt status kept", r, 32'hA5C3_0F69);
		exec(lsu_pkg::OP_MFS, 4'h3, 4'h9, 16'h0000);
		rd(gpr(4'h9), r);
		chk("control read", r, 32'hA5C3_0F69);
		$display("t_sys done");
	endtask

	task automatic t_priv();
		logic [7:0] po [12] = '{lsu_pkg::OP_MTS, lsu_pkg::OP_MFS, lsu_pkg::OP_CONTROL_BIT_SET_OP,
			lsu_pkg::OP_CONTROL_BIT_CLEAR_OP, lsu_pkg::OP_LPS, lsu_pkg::OP_WAIT, lsu_pkg::OP_MTS,
			lsu_pkg::OP_MFS, lsu_pkg::OP_CONTROL_BIT_SET_OP, lsu_pkg::OP_SVC, lsu_pkg::OP_SRI,
			lsu_pkg::OP_AND};
		logic [3:0] ps [12] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'hA, 4'hF, 4'hF, 4'h3,
			4'h3, 4'h3};
		int         n;
		wr(32'h8, 32'h1);
		rd(32'h4, r);
		chk("status mode", r & 32'h18, 32'h10);
		wr(gpr(4'h1), 32'h1);
		for (int j = 0; j < 12; j++) begin
			n = pc_cnt;
			exec(po[j], ps[j], 4'h1, 16'h0000);
			rd(system_control_register(4'h3), r);
			chk("control kept", r, 32'hA5C3_0F69);
			chk("trap pulses", 32'(pc_cnt - n), (j < 6) ? 32'h1 : 32'h0);
		end
		rd(system_control_register(4'hA), r);
		chk("quotient written", r, 32'h1);
		rd(32'h4, r);
		chk("status trap", r & 32'h8, 32'h8);
		rd(system_control_register(4'hB), r);
		chk("check status", r & 32'h10, 32'h10);
		$display("t_priv done");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_logic();
		t_clz();
		t_shift();
		t_sys();
		t_priv();
		wrap_up();
	end
endmodule
